// ---- src/trc_cadence.sv ----
`default_nettype none
module trc_cadence
   import trc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic on_en,
   input wire logic off_en,
   input wire logic zc_stop,
   input wire logic reload,
   input wire logic zero_cross,
   input wire logic tick,
   input wire trc_cad_len_t len,
   output trc_cad_out_t out
);
   trc_cad_state_t s_r;
   trc_cad_state_t s_nxt;

   always_comb begin
      logic go_off;
      logic expired;
      go_off = 1'b0;
      expired = (s_r.cnt <= 16'h0001);
      s_nxt = s_r;
      s_nxt.on_exp = 1'b0;
      s_nxt.off_exp = 1'b0;
      if (!enable) begin
         s_nxt.st = TRC_CAD_IDLE;
      end else begin
         unique case (s_r.st)
            TRC_CAD_IDLE: begin
               s_nxt.st = TRC_CAD_ON;
               s_nxt.cnt = len.on_len;
            end
            TRC_CAD_ON: begin
               // without the on timer the tone runs continuously
               if (on_en && tick) begin
                  if (expired) begin
                     s_nxt.on_exp = 1'b1;
                     if (zc_stop) begin
                        s_nxt.st = TRC_CAD_ZWAIT;
                     end else begin
                        go_off = 1'b1;
                     end
                  end else begin
                     s_nxt.cnt = s_r.cnt - 16'h0001;
                  end
               end
            end
            TRC_CAD_ZWAIT: begin
               if (zero_cross) begin
                  go_off = 1'b1;
               end
            end
            TRC_CAD_OFF: begin
               if (tick) begin
                  if (expired) begin
                     s_nxt.off_exp = 1'b1;
                     if (reload) begin
                        s_nxt.st = TRC_CAD_ON;
                        s_nxt.cnt = len.on_len;
                     end else begin
                        s_nxt.st = TRC_CAD_DONE;
                     end
                  end else begin
                     s_nxt.cnt = s_r.cnt - 16'h0001;
                  end
               end
            end
            TRC_CAD_DONE: begin
               s_nxt.st = TRC_CAD_DONE;
            end
            default: begin
               s_nxt.st = TRC_CAD_IDLE;
            end
         endcase
         if (go_off) begin
            if (off_en) begin
               s_nxt.st = TRC_CAD_OFF;
               s_nxt.cnt = len.off_len;
            end else begin
               s_nxt.st = TRC_CAD_DONE;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '{st: TRC_CAD_IDLE, cnt: 16'h0000, on_exp: 1'b0, off_exp: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out.active = (s_r.st == TRC_CAD_ON) || (s_r.st == TRC_CAD_ZWAIT);
   assign out.on_expire = s_r.on_exp;
   assign out.off_expire = s_r.off_exp;
endmodule
`default_nettype wire

// ---- src/trc_pkg.sv ----
`default_nettype none
package trc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] TRC_IDX_TONE1 = 8'h20;
   localparam logic [7:0] TRC_IDX_TONE2 = 8'h21;
   localparam logic [7:0] TRC_IDX_RING = 8'h22;
   localparam logic [7:0] TRC_IDX_IRQ_STAT = 8'h3c;
   localparam logic [7:0] TRC_IDX_IRQ_MASK = 8'h3d;
   localparam int TRC_ADDR_W = 10;

   // control register bit positions
   localparam int TRC_B_ACTIVE = 7;
   localparam int TRC_B_RELOAD = 6;
   localparam int TRC_B_ZC = 5;
   localparam int TRC_B_ON_LINE = 5;
   localparam int TRC_B_ON_EN = 4;
   localparam int TRC_B_OFF_EN = 3;
   localparam int TRC_B_EN = 2;
   localparam int TRC_B_DC_OFS = 1;
   localparam int TRC_B_ROUTE_TX = 0;
   localparam int TRC_B_ROUTE_RX = 1;
   localparam int TRC_B_SHAPE = 0;

   // interrupt status and mask bit positions
   localparam int TRC_IRQ_T1_ON = 0;
   localparam int TRC_IRQ_T1_OFF = 1;
   localparam int TRC_IRQ_T2_ON = 2;
   localparam int TRC_IRQ_T2_OFF = 3;
   localparam int TRC_IRQ_RG_ON = 4;
   localparam int TRC_IRQ_RG_OFF = 5;

   // reset values
   localparam logic [6:0] TRC_TONE_RST = 7'h00;
   localparam logic [3:0] TRC_RING_RST = 4'h0;
   localparam logic [5:0] TRC_IRQ_RST = 6'h00;

   // cadence tick: one timer lsb
   localparam int TRC_CLK_NS = 10;
   localparam int TRC_TICK_NS = 125000;
   localparam int TRC_TICK_CYC = (TRC_TICK_NS + TRC_CLK_NS - 1) / TRC_CLK_NS;

   typedef struct packed {
      logic reload;
      logic zc_stop;
      logic on_en;
      logic off_en;
      logic enable;
      logic [1:0] route;
   } trc_osc_cfg_t;

   typedef struct packed {
      logic on_en;
      logic off_en;
      logic dc_ofs;
      logic shape;
   } trc_ring_cfg_t;

   typedef struct packed {
      logic [15:0] on_len;
      logic [15:0] off_len;
   } trc_cad_len_t;

   typedef struct packed {
      logic active;
      logic on_expire;
      logic off_expire;
   } trc_cad_out_t;

   typedef enum logic [4:0] {
      TRC_CAD_IDLE = 5'b00001,
      TRC_CAD_ON = 5'b00010,
      TRC_CAD_ZWAIT = 5'b00100,
      TRC_CAD_OFF = 5'b01000,
      TRC_CAD_DONE = 5'b10000
   } trc_cad_st_t;

   typedef struct packed {
      trc_cad_st_t st;
      logic [15:0] cnt;
      logic on_exp;
      logic off_exp;
   } trc_cad_state_t;

   typedef struct packed {
      trc_osc_cfg_t tone1;
      trc_osc_cfg_t tone2;
      trc_ring_cfg_t ring;
      logic ring_en;
      logic on_line;
      logic [5:0] irq_stat;
      logic [5:0] irq_mask;
      logic [7:0] rdata;
      logic [15:0] tick_cnt;
      logic tick;
      logic t1_tx;
      logic t1_rx;
      logic t2_tx;
      logic t2_rx;
   } trc_top_state_t;
endpackage
`default_nettype wire

// ---- src/trc_top.sv ----
// The implementer's own choice: the plain strobed port.
`default_nettype none
// Functional notes
// - tone control bit 7 reads back whether that tone output is active.
// - tone one without reload stops for good after its off timer expires.
// - tone one with reload restarts its cadence after the off timer.
// - tone one bit 5 chooses stop at timer expiry or next zero crossing.
// - tone two bit 5 chooses stop at timer expiry or next zero crossing.
// - tone one bits 4 and 3 enable its on and off timers.
// - tone two bits 4 and 3 enable its on and off timers.
// - tone control bit 2 enables or disables that oscillator.
// - tone bits 1:0 route output to none, transmit, receive or both.
// - ringing control bit 7 reads back whether ringing output is active.
// - ringing joins or leaves the line only at a feed crossing.
// - ringing control bit 5 reads one only while ringing is on line.
// - ringing bits 4 and 3 enable its on and off timers.
// - ringing bit 2 reports, read only, whether ringing is enabled.
// - ringing bit 1 adds a dc offset to the ringing waveform.
// - ringing bit 0 selects sinusoid or trapezoid waveshape.
// - every on and off timer expiry may interrupt, each with mask bit.
module trc_top
   import trc_pkg::*;
#(
   parameter int TICK_CYCLES = TRC_TICK_CYC
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [TRC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire trc_cad_len_t tone1_len,
   input wire trc_cad_len_t tone2_len,
   input wire trc_cad_len_t ring_len,
   input wire logic tone1_zero_cross,
   input wire logic tone2_zero_cross,
   input wire logic ring_zero_cross,
   input wire logic ring_enable_req,
   input wire logic ring_line_cross,
   output logic tone1_run,
   output logic tone2_run,
   output logic tone1_tx,
   output logic tone1_rx,
   output logic tone2_tx,
   output logic tone2_rx,
   output logic ring_run,
   output logic ring_drive,
   output logic ring_dc_offset_en,
   output logic ring_shape_select
);
   trc_top_state_t s_r;
   trc_top_state_t s_nxt;
   trc_cad_out_t t1_out;
   trc_cad_out_t t2_out;
   trc_cad_out_t rg_out;

   function automatic logic hit(input logic [TRC_ADDR_W-1:0] a, input logic [7:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction

   // tone one: software sets reload for keyed signalling
   trc_cadence u_tone1 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .enable(s_r.tone1.enable),
      .on_en(s_r.tone1.on_en),
      .off_en(s_r.tone1.off_en),
      .zc_stop(s_r.tone1.zc_stop),
      .reload(s_r.tone1.reload),
      .zero_cross(tone1_zero_cross),
      .tick(s_r.tick),
      .len(tone1_len),
      .out(t1_out)
   );

   // tone two has no reload choice: its cadence repeats after each off timer expiry
   trc_cadence u_tone2 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .enable(s_r.tone2.enable),
      .on_en(s_r.tone2.on_en),
      .off_en(s_r.tone2.off_en),
      .zc_stop(s_r.tone2.zc_stop),
      .reload(1'b1),
      .zero_cross(tone2_zero_cross),
      .tick(s_r.tick),
      .len(tone2_len),
      .out(t2_out)
   );

   // ringing stops at timer expiry and repeats its cadence
   trc_cadence u_ring (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .enable(s_r.ring_en),
      .on_en(s_r.ring.on_en),
      .off_en(s_r.ring.off_en),
      .zc_stop(1'b0),
      .reload(1'b1),
      .zero_cross(ring_zero_cross),
      .tick(s_r.tick),
      .len(ring_len),
      .out(rg_out)
   );

   always_comb begin
      logic [5:0] events;
      logic [7:0] rd_val;
      logic wr_t1;
      logic wr_t2;
      logic wr_rg;
      logic wr_mask;
      logic rd_stat;
      events = '0;
      rd_val = 8'h00;
      s_nxt = s_r;

      // write decode and status read decode
      wr_t1 = reg_wr && hit(reg_addr, TRC_IDX_TONE1);
      wr_t2 = reg_wr && hit(reg_addr, TRC_IDX_TONE2);
      wr_rg = reg_wr && hit(reg_addr, TRC_IDX_RING);
      wr_mask = reg_wr && hit(reg_addr, TRC_IDX_IRQ_MASK);
      rd_stat = reg_rd && hit(reg_addr, TRC_IDX_IRQ_STAT);

      // timer lsb prescaler
      if (s_r.tick_cnt == 16'(TICK_CYCLES - 1)) begin
         s_nxt.tick_cnt = 16'h0000;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
         s_nxt.tick = 1'b0;
      end

      if (wr_t1) begin
         s_nxt.tone1.reload = reg_wdata[TRC_B_RELOAD];
         s_nxt.tone1.zc_stop = reg_wdata[TRC_B_ZC];
         s_nxt.tone1.on_en = reg_wdata[TRC_B_ON_EN];
         s_nxt.tone1.off_en = reg_wdata[TRC_B_OFF_EN];
         s_nxt.tone1.enable = reg_wdata[TRC_B_EN];
         s_nxt.tone1.route = reg_wdata[TRC_B_ROUTE_RX:TRC_B_ROUTE_TX];
      end
      if (wr_t2) begin
         s_nxt.tone2.reload = 1'b0;
         s_nxt.tone2.zc_stop = reg_wdata[TRC_B_ZC];
         s_nxt.tone2.on_en = reg_wdata[TRC_B_ON_EN];
         s_nxt.tone2.off_en = reg_wdata[TRC_B_OFF_EN];
         s_nxt.tone2.enable = reg_wdata[TRC_B_EN];
         s_nxt.tone2.route = reg_wdata[TRC_B_ROUTE_RX:TRC_B_ROUTE_TX];
      end
      if (wr_rg) begin
         s_nxt.ring.on_en = reg_wdata[TRC_B_ON_EN];
         s_nxt.ring.off_en = reg_wdata[TRC_B_OFF_EN];
         s_nxt.ring.dc_ofs = reg_wdata[TRC_B_DC_OFS];
         s_nxt.ring.shape = reg_wdata[TRC_B_SHAPE];
      end
      if (wr_mask) begin
         s_nxt.irq_mask = reg_wdata[5:0];
      end

      // ringing enable comes from the line feed side
      s_nxt.ring_en = ring_enable_req;

      // ringing joins or leaves the line at a feed crossing only
      if (ring_line_cross) begin
         s_nxt.on_line = rg_out.active;
      end

      // routed path enables
      s_nxt.t1_tx = t1_out.active && s_r.tone1.route[TRC_B_ROUTE_TX];
      s_nxt.t1_rx = t1_out.active && s_r.tone1.route[TRC_B_ROUTE_RX];
      s_nxt.t2_tx = t2_out.active && s_r.tone2.route[TRC_B_ROUTE_TX];
      s_nxt.t2_rx = t2_out.active && s_r.tone2.route[TRC_B_ROUTE_RX];

      // sticky timer events; a new event wins over read-clear
      events[TRC_IRQ_T1_ON] = t1_out.on_expire;
      events[TRC_IRQ_T1_OFF] = t1_out.off_expire;
      events[TRC_IRQ_T2_ON] = t2_out.on_expire;
      events[TRC_IRQ_T2_OFF] = t2_out.off_expire;
      events[TRC_IRQ_RG_ON] = rg_out.on_expire;
      events[TRC_IRQ_RG_OFF] = rg_out.off_expire;
      if (rd_stat) begin
         s_nxt.irq_stat = events;
      end else begin
         s_nxt.irq_stat = s_r.irq_stat | events;
      end

      // read mux; data stand only in the cycle after the strobe
      if (hit(reg_addr, TRC_IDX_TONE1)) begin
         rd_val[TRC_B_ACTIVE] = t1_out.active;
         rd_val[6:0] = s_r.tone1;
      end else if (hit(reg_addr, TRC_IDX_TONE2)) begin
         rd_val[TRC_B_ACTIVE] = t2_out.active;
         rd_val[5:0] = s_r.tone2[5:0];
      end else if (hit(reg_addr, TRC_IDX_RING)) begin
         rd_val[TRC_B_ACTIVE] = rg_out.active;
         rd_val[TRC_B_ON_LINE] = s_r.on_line;
         rd_val[TRC_B_ON_EN] = s_r.ring.on_en;
         rd_val[TRC_B_OFF_EN] = s_r.ring.off_en;
         rd_val[TRC_B_EN] = s_r.ring_en;
         rd_val[TRC_B_DC_OFS] = s_r.ring.dc_ofs;
         rd_val[TRC_B_SHAPE] = s_r.ring.shape;
      end else if (hit(reg_addr, TRC_IDX_IRQ_STAT)) begin
         rd_val[5:0] = s_r.irq_stat;
      end else if (hit(reg_addr, TRC_IDX_IRQ_MASK)) begin
         rd_val[5:0] = s_r.irq_mask;
      end
      s_nxt.rdata = reg_rd ? rd_val : 8'h00;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r.tone1 <= TRC_TONE_RST;
         s_r.tone2 <= TRC_TONE_RST;
         s_r.ring <= TRC_RING_RST;
         s_r.ring_en <= 1'b0;
         s_r.on_line <= 1'b0;
         s_r.irq_stat <= TRC_IRQ_RST;
         s_r.irq_mask <= TRC_IRQ_RST;
         s_r.rdata <= 8'h00;
         s_r.tick_cnt <= 16'h0000;
         s_r.tick <= 1'b0;
         s_r.t1_tx <= 1'b0;
         s_r.t1_rx <= 1'b0;
         s_r.t2_tx <= 1'b0;
         s_r.t2_rx <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign irq = |(s_r.irq_stat & s_r.irq_mask);
   assign tone1_run = t1_out.active;
   assign tone2_run = t2_out.active;
   assign tone1_tx = s_r.t1_tx;
   assign tone1_rx = s_r.t1_rx;
   assign tone2_tx = s_r.t2_tx;
   assign tone2_rx = s_r.t2_rx;
   assign ring_run = rg_out.active;
   assign ring_drive = s_r.on_line;
   assign ring_dc_offset_en = s_r.ring.dc_ofs;
   assign ring_shape_select = s_r.ring.shape;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top
   import trc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   localparam logic [9:0] A_T1 = {TRC_IDX_TONE1, 2'b00};
   localparam logic [9:0] A_T2 = {TRC_IDX_TONE2, 2'b00};
   localparam logic [9:0] A_RG = {TRC_IDX_RING, 2'b00};
   localparam logic [9:0] A_ST = {TRC_IDX_IRQ_STAT, 2'b00};
   localparam logic [9:0] A_MK = {TRC_IDX_IRQ_MASK, 2'b00};
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   trc_cad_len_t cad_len = {16'h0003, 16'h0002};
   logic [1:0] zc = 2'h0;
   logic ring_req = 1'b0;
   logic line_x = 1'b0;
   wire [7:0] reg_rdata;
   wire irq, ring_run, ring_drive, ring_dc, ring_shape;
   wire [1:0] run, tx, rx;
   wire [2:0] runs;
   logic [9:0] adr [6] = '{A_T1, A_T2, A_RG, A_ST, A_MK, 10'h000};
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int wc, i, n, o;
   assign runs = {ring_run, run};
   always #5 sys_clk = ~sys_clk;

   trc_top #(.TICK_CYCLES(TK)) i_dut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
      .tone1_len(cad_len), .tone2_len(cad_len), .ring_len(cad_len),
      .tone1_zero_cross(zc[0]), .tone2_zero_cross(zc[1]), .ring_zero_cross(1'b0),
      .ring_enable_req(ring_req), .ring_line_cross(line_x),
      .tone1_run(run[0]), .tone2_run(run[1]), .tone1_tx(tx[0]), .tone1_rx(rx[0]),
      .tone2_tx(tx[1]), .tone2_rx(rx[1]), .ring_run(ring_run), .ring_drive(ring_drive),
      .ring_dc_offset_en(ring_dc), .ring_shape_select(ring_shape));

   task automatic test_done;
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, exp);
   endtask

   // hit says whether the level is expected within lim cycles
   task automatic wait_run(input int s, input logic v, input int lim, input logic hit);
      wc = 0;
      while (runs[s] !== v && wc < lim) begin
         @(negedge sys_clk);
         wc++;
      end
      chk(wc < lim, hit);
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails++;
         test_done;
      end
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 6; i++) rd(adr[i], 8'h00);
      wr(A_T1 + 10'h001, 8'h04);
      rd(A_T1, 8'h00);
      wr(A_T1, 8'h7b);
      rd(A_T1, 8'h7b);
      wr(A_T2, 8'hfb);
      rd(A_T2, 8'h3b);
      wr(A_RG, 8'hff);
      rd(A_RG, 8'h1b);
      chk({ring_dc, ring_shape}, 2'b11);
      wr(A_RG, 8'h01);
      @(negedge sys_clk);
      chk({ring_dc, ring_shape}, 2'b01);
      wr(A_RG, 8'h00);
      wr(A_T1, 8'h00);
      wr(A_T2, 8'h00);
      // every route code on both tones
      for (i = 0; i < 8; i++) begin
         n = i % 4;
         o = i / 4;
         wr(o ? A_T2 : A_T1, 8'h04 | n[7:0]);
         repeat (3) @(negedge sys_clk);
         chk({run[o], tx[o], rx[o]}, {1'b1, n[0], n[1]});
         rd(o ? A_T2 : A_T1, 8'h84 | n[7:0]);
         wr(o ? A_T2 : A_T1, 8'h00);
         repeat (3) @(negedge sys_clk);
         chk({run[o], tx[o], rx[o]}, 3'b000);
      end
      // single on phase, masked then unmasked interrupt
      wr(A_MK, 8'h3e);
      wr(A_T1, 8'h14);
      wait_run(0, 1'b1, 4, 1'b1);
      wait_run(0, 1'b0, 40, 1'b1);
      chk(wc >= 2 * TK && wc <= 3 * TK + 2, 1'b1);
      wait_run(0, 1'b1, 30, 1'b0);
      chk(irq, 1'b0);
      wr(A_MK, 8'h3f);
      @(negedge sys_clk);
      chk(irq, 1'b1);
      rd(A_MK, 8'h3f);
      rd(A_ST, 8'h01);
      rd(A_ST, 8'h00);
      chk(irq, 1'b0);
      wr(A_T1, 8'h00);
      wr(A_T1, 8'h5c);
      for (i = 0; i < 2; i++) begin
         wait_run(0, 1'b1, 40, 1'b1);
         wait_run(0, 1'b0, 40, 1'b1);
      end
      wait_run(0, 1'b1, 40, 1'b1);
      rd(A_ST, 8'h03);
      wr(A_T1, 8'h00);
      wr(A_T1, 8'h1c);
      wait_run(0, 1'b1, 8, 1'b1);
      wait_run(0, 1'b0, 40, 1'b1);
      wait_run(0, 1'b1, 40, 1'b0);
      rd(A_ST, 8'h03);
      wr(A_T1, 8'h00);
      // stop waits for the zero crossing on both tones
      for (o = 0; o < 2; o++) begin
         wr(o ? A_T2 : A_T1, 8'h34);
         wait_run(o, 1'b1, 8, 1'b1);
         repeat (5 * TK) @(negedge sys_clk);
         chk(run[o], 1'b1);
         @(posedge sys_clk) zc[o] <= 1'b1;
         @(posedge sys_clk) zc[o] <= 1'b0;
         wait_run(o, 1'b0, 3, 1'b1);
         wr(o ? A_T2 : A_T1, 8'h00);
      end
      rd(A_ST, 8'h05);
      // ringing joins and leaves the line only at crossings
      @(posedge sys_clk) ring_req <= 1'b1;
      wait_run(2, 1'b1, 4, 1'b1);
      rd(A_RG, 8'h84);
      @(posedge sys_clk) line_x <= 1'b1;
      @(posedge sys_clk) line_x <= 1'b0;
      rd(A_RG, 8'ha4);
      @(posedge sys_clk) ring_req <= 1'b0;
      wait_run(2, 1'b0, 4, 1'b1);
      rd(A_RG, 8'h20);
      @(posedge sys_clk) line_x <= 1'b1;
      @(posedge sys_clk) line_x <= 1'b0;
      rd(A_RG, 8'h00);
      wr(A_RG, 8'h18);
      @(posedge sys_clk) ring_req <= 1'b1;
      for (i = 0; i < 2; i++) begin
         wait_run(2, 1'b1, 40, 1'b1);
         wait_run(2, 1'b0, 40, 1'b1);
      end
      rd(A_ST, 8'h30);
      test_done;
   end
endmodule
`default_nettype wire

// ---- tb/trc_top_chk.sv ----
`default_nettype none
module trc_top_chk
   import trc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [TRC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic ring_enable_req,
   input wire logic ring_line_cross,
   input wire logic tone1_run,
   input wire logic tone2_run,
   input wire logic tone1_tx,
   input wire logic tone1_rx,
   input wire logic tone2_tx,
   input wire logic tone2_rx,
   input wire logic ring_run,
   input wire logic ring_drive,
   input wire logic ring_dc_offset_en,
   input wire logic ring_shape_select
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic ring_wr;
   assign ring_wr = reg_wr && (reg_addr == {TRC_IDX_RING, 2'b00});

   a_tone1_route: assert property ((tone1_tx || tone1_rx) |-> $past(tone1_run))
      else $error("tone one routed while not running");
   a_tone2_route: assert property ((tone2_tx || tone2_rx) |-> $past(tone2_run))
      else $error("tone two routed while not running");
   a_route_quiet: assert property (!tone1_run && !tone2_run
      |=> !(tone1_tx || tone1_rx || tone2_tx || tone2_rx))
      else $error("route outputs stay up after tones stop");
   a_ring_hold: assert property (!$past(ring_line_cross) |-> $stable(ring_drive))
      else $error("ringing drive changed away from a feed crossing");
   a_ring_join: assert property ($past(ring_line_cross) |-> ring_drive == $past(ring_run))
      else $error("ringing drive does not follow ringing at crossing");
   a_ring_disable: assert property ($fell(ring_enable_req) |-> ##2 !ring_run)
      else $error("ringing still active after disable");
   a_dc_follows: assert property ($past(ring_wr) |-> ring_dc_offset_en == $past(reg_wdata[1]))
      else $error("dc offset output differs from written bit");
   a_shape_follows: assert property ($past(ring_wr) |-> ring_shape_select == $past(reg_wdata[0]))
      else $error("waveshape output differs from written bit");
   a_ring_cfg_stable: assert property (($changed(ring_dc_offset_en) || $changed(ring_shape_select))
      |-> $past(ring_wr))
      else $error("ringing config changed without a write");
endmodule
bind trc_top trc_top_chk i_chk (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .ring_enable_req, .ring_line_cross, .tone1_run, .tone2_run, .tone1_tx, .tone1_rx,
   .tone2_tx, .tone2_rx, .ring_run, .ring_drive, .ring_dc_offset_en, .ring_shape_select);
`default_nettype wire
